// ===== hdl/hpc_host_port.sv
// Purpose: Host port command vectoring, boot loading support and both data directions.
// Assumes: Host bus inputs are synchronous to mclk_in; one host access per asserted cycle.
// Notes: Core registers answer after one wait cycle on Avalon-MM.
//
// Design decisions made here: register access over Avalon-MM and the register addresses.
`timescale 1ns/1ps
module hpc_host_port #(
    parameter int WORD_W = 24,
    parameter int BOOT_WORDS = hpc_pkg::HPC_BOOT_WORDS
) (
    // Clock and reset.
    input wire logic mclk_in,
    input wire logic rst_in,
    // Host byte bus.
    input hpc_pkg::hpc_host_req_type host_req_in,
    output logic [7:0] host_rdata_out,
    output logic host_request_pin_out,
    // Core Avalon-MM slave.
    input wire logic [3:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [31:0] avs_writedata_in,
    output logic [31:0] avs_readdata_out,
    output logic avs_waitrequest_out,
    // Core exception handshake.
    input wire logic core_irq_enable_in,
    input wire logic exc_ack_in,
    output logic exc_req_out,
    output logic [15:0] exc_vector_out,
    // Boot mode pins and boot status.
    input wire logic boot_mode_pin_a_in,
    input wire logic boot_mode_pin_b_in,
    input wire logic boot_mode_pin_c_in,
    output logic boot_load_out,
    output logic boot_done_out
);
    import hpc_pkg::*;

    // Host-side control and command vector state.
    logic [7:0] host_side_control_reg;
    logic [5:0] vector_number_reg;
    logic command_request_bit_reg;
    // Host-to-core path: transmit bytes, empty flag, core receive word and flag.
    logic [WORD_W-1:0] transmit_byte_registers_reg;
    logic host_transmit_empty_reg;
    logic [WORD_W-1:0] dsp_receive_register_reg;
    logic dsp_receive_full_reg;
    // Core-to-host path: transmit word, empty flag, receive bytes and flag.
    logic [WORD_W-1:0] dsp_transmit_register_reg;
    logic dsp_transmit_empty_reg;
    logic [WORD_W-1:0] host_receive_reg;
    logic host_receive_full_reg;
    // Core-side control bits.
    logic [2:0] dsp_side_control_reg;
    // Bus answer and exception state.
    logic avs_ack_reg;
    logic exc_req_reg;
    logic [15:0] exc_vector_reg;
    // Boot capture and word count.
    logic boot_sampled_reg;
    logic boot_load_reg;
    logic [$clog2(BOOT_WORDS+1)-1:0] boot_count_reg;
    logic boot_done_reg;
    logic [7:0] host_rdata_reg;

    // Decoded strobes.
    logic host_wr;
    logic host_rd;
    logic avs_take;
    logic core_wr_control;
    logic core_wr_transmit;
    logic core_rd_receive;
    logic init_now;
    logic dma_off;
    logic command_pending;
    logic move_to_core;
    logic move_to_host;

    // Decodes one host write or read at a given byte address.
    function automatic logic host_hit(input hpc_host_req_type r, input logic wr, input logic [2:0] a);
        host_hit = (wr ? r.write : r.read) && (r.addr == a);
    endfunction

    assign host_wr = host_req_in.write;
    assign host_rd = host_req_in.read;
    // An Avalon access completes in the cycle its acknowledge is high.
    assign avs_take = (avs_read_in || avs_write_in) && avs_ack_reg;
    assign core_wr_control = avs_take && avs_write_in && (avs_address_in == HPC_OFS_CONTROL);
    assign core_wr_transmit = avs_take && avs_write_in && (avs_address_in == HPC_OFS_TRANSMIT);
    assign core_rd_receive = avs_take && avs_read_in && (avs_address_in == HPC_OFS_RECEIVE);
    // Initialisation runs in the cycle after the host sets the bit.
    assign init_now = host_side_control_reg[HPC_HC_INIT];
    // Command exceptions are usable only with both mode bits clear.
    assign dma_off = !host_side_control_reg[HPC_HC_MODE_HI] && !host_side_control_reg[HPC_HC_MODE_LO];
    assign command_pending = command_request_bit_reg;
    assign move_to_core = !host_transmit_empty_reg && !dsp_receive_full_reg && !init_now;
    assign move_to_host = !host_receive_full_reg && !dsp_transmit_empty_reg && !init_now;

    // Waitrequest is high for the first cycle of each request and low on the answering cycle.
    assign avs_waitrequest_out = (avs_read_in || avs_write_in) && !avs_ack_reg;
    assign exc_req_out = exc_req_reg;
    assign exc_vector_out = exc_vector_reg;
    assign boot_load_out = boot_load_reg;
    assign boot_done_out = boot_done_reg;
    assign host_rdata_out = host_rdata_reg;

    // Acknowledge toggles so each request sees exactly one wait cycle.
    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            avs_ack_reg <= 1'b0;
        end else begin
            avs_ack_reg <= (avs_read_in || avs_write_in) && !avs_ack_reg;
        end
    end

    // Host control register; the initialise bit clears itself after one cycle.
    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            host_side_control_reg <= 8'h00;
        end else if (host_hit(host_req_in, 1'b1, HPC_HA_CONTROL)) begin
            host_side_control_reg <= host_req_in.wdata;
        end else if (init_now) begin
            host_side_control_reg[HPC_HC_INIT] <= 1'b0;
        end
    end

    // Command vector and request; a host write wins over a same-cycle acknowledge.
    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            vector_number_reg <= HPC_CV_RESET;
            command_request_bit_reg <= 1'b0;
        end else if (host_hit(host_req_in, 1'b1, HPC_HA_VECTOR)) begin
            // Vector and request may be written in one access; clearing request cancels.
            vector_number_reg <= host_req_in.wdata[5:0];
            command_request_bit_reg <= host_req_in.wdata[HPC_CV_REQ];
        end else if (exc_ack_in && exc_req_reg && (exc_vector_reg == {9'h000, vector_number_reg, 1'b0})
                     && command_request_bit_reg && !dsp_receive_full_reg
                     && !(dsp_transmit_empty_reg && dsp_side_control_reg[HPC_DC_TX_IE])) begin
            command_request_bit_reg <= 1'b0;
        end
    end

    // Host transmit bytes; writing the low byte last launches the word.
    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            transmit_byte_registers_reg <= '0;
            host_transmit_empty_reg <= 1'b1;
        end else begin
            if (host_hit(host_req_in, 1'b1, HPC_HA_HIGH)) begin
                transmit_byte_registers_reg[23:16] <= host_req_in.wdata;
            end
            if (host_hit(host_req_in, 1'b1, HPC_HA_MID)) begin
                transmit_byte_registers_reg[15:8] <= host_req_in.wdata;
            end
            if (host_hit(host_req_in, 1'b1, HPC_HA_LOW)) begin
                transmit_byte_registers_reg[7:0] <= host_req_in.wdata;
                host_transmit_empty_reg <= 1'b0;
            end else if (move_to_core || init_now) begin
                host_transmit_empty_reg <= 1'b1;
            end
        end
    end

    // Core receive word; a core read of it frees it for the next move.
    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            dsp_receive_register_reg <= '0;
            dsp_receive_full_reg <= 1'b0;
        end else if (move_to_core) begin
            dsp_receive_register_reg <= transmit_byte_registers_reg;
            dsp_receive_full_reg <= 1'b1;
        end else if (core_rd_receive || init_now) begin
            dsp_receive_full_reg <= 1'b0;
        end
    end

    // Core transmit word; a write empties nothing until the move takes it.
    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            dsp_transmit_register_reg <= '0;
            dsp_transmit_empty_reg <= 1'b1;
        end else if (core_wr_transmit) begin
            dsp_transmit_register_reg <= avs_writedata_in[WORD_W-1:0];
            dsp_transmit_empty_reg <= 1'b0;
        end else if (move_to_host || init_now) begin
            dsp_transmit_empty_reg <= 1'b1;
        end
    end

    // Host receive bytes; the move sets full and a low-byte read clears it.
    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            host_receive_reg <= '0;
            host_receive_full_reg <= 1'b0;
        end else if (move_to_host) begin
            host_receive_reg <= dsp_transmit_register_reg;
            host_receive_full_reg <= 1'b1;
        end else if (host_hit(host_req_in, 1'b0, HPC_HA_LOW) || init_now) begin
            host_receive_full_reg <= 1'b0;
        end
    end

    // Host read data, registered one cycle after the read strobe.
    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            host_rdata_reg <= 8'h00;
        end else if (host_rd) begin
            case (host_req_in.addr)
                HPC_HA_CONTROL: host_rdata_reg <= host_side_control_reg;
                // Request bit shows the host whether the command was accepted.
                HPC_HA_VECTOR: host_rdata_reg <= {command_request_bit_reg, 1'b0, vector_number_reg};
                HPC_HA_STATUS: host_rdata_reg <= {6'h00, host_transmit_empty_reg, host_receive_full_reg};
                HPC_HA_UNUSED: host_rdata_reg <= 8'h00;
                HPC_HA_HIGH: host_rdata_reg <= host_receive_reg[23:16];
                HPC_HA_MID: host_rdata_reg <= host_receive_reg[15:8];
                HPC_HA_LOW: host_rdata_reg <= host_receive_reg[7:0];
                default: host_rdata_reg <= 8'h00;
            endcase
        end
    end

    // Request pin: receive full when enabled, or transmit empty when that is enabled.
    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            host_request_pin_out <= 1'b0;
        end else begin
            host_request_pin_out <= (host_side_control_reg[HPC_HC_RX_REQ] && host_receive_full_reg)
                || (host_side_control_reg[HPC_HC_TX_REQ] && host_transmit_empty_reg);
        end
    end

    // Core control register.
    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            dsp_side_control_reg <= 3'h0;
        end else if (core_wr_control) begin
            dsp_side_control_reg <= avs_writedata_in[2:0];
        end
    end

    // Avalon read data: status shows pending command, flags and host flag zero.
    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            avs_readdata_out <= 32'h00000000;
        end else if (avs_read_in && !avs_ack_reg) begin
            case (avs_address_in)
                HPC_OFS_CONTROL: avs_readdata_out <= {29'h00000000, dsp_side_control_reg};
                HPC_OFS_STATUS: avs_readdata_out <= {28'h0000000, host_side_control_reg[HPC_HC_FLAG0],
                    command_pending, dsp_transmit_empty_reg, dsp_receive_full_reg};
                HPC_OFS_TRANSMIT: avs_readdata_out <= {{(32-WORD_W){1'b0}}, dsp_transmit_register_reg};
                HPC_OFS_RECEIVE: avs_readdata_out <= {{(32-WORD_W){1'b0}}, dsp_receive_register_reg};
                default: avs_readdata_out <= 32'h00000000;
            endcase
        end
    end

    // Exception request: receive first, then transmit, then host command.
    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            exc_req_reg <= 1'b0;
            exc_vector_reg <= 16'h0000;
        end else if (!core_irq_enable_in) begin
            exc_req_reg <= 1'b0;
        end else if (dsp_receive_full_reg && dsp_side_control_reg[HPC_DC_RX_IE]) begin
            exc_req_reg <= 1'b1;
            exc_vector_reg <= HPC_VEC_RECEIVE;
        end else if (dsp_transmit_empty_reg && dsp_side_control_reg[HPC_DC_TX_IE]) begin
            exc_req_reg <= 1'b1;
            exc_vector_reg <= HPC_VEC_TRANSMIT;
        end else if (command_pending && dsp_side_control_reg[HPC_DC_CMD_IE] && dma_off
                     && !(host_hit(host_req_in, 1'b1, HPC_HA_VECTOR) && !host_req_in.wdata[HPC_CV_REQ])) begin
            // Vector zero is passed as any other; it resets no hardware here.
            exc_req_reg <= 1'b1;
            exc_vector_reg <= {10'h000, vector_number_reg} << HPC_VEC_SHIFT;
        end else begin
            exc_req_reg <= 1'b0;
        end
    end

    // Boot mode pins are caught on the first edge after reset release.
    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            boot_sampled_reg <= 1'b0;
            boot_load_reg <= 1'b0;
        end else if (!boot_sampled_reg) begin
            boot_sampled_reg <= 1'b1;
            boot_load_reg <= ({boot_mode_pin_c_in, boot_mode_pin_b_in, boot_mode_pin_a_in} == HPC_BOOT_HOST);
        end
    end

    // Boot word count ends at the limit or when the host raises flag zero.
    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            boot_count_reg <= '0;
            boot_done_reg <= 1'b0;
        end else if (boot_load_reg && !boot_done_reg) begin
            if (host_side_control_reg[HPC_HC_FLAG0]) begin
                boot_done_reg <= 1'b1;
            end else if (core_rd_receive) begin
                boot_count_reg <= boot_count_reg + 1'b1;
                boot_done_reg <= (boot_count_reg == ($bits(boot_count_reg))'(BOOT_WORDS - 1));
            end
        end
    end
endmodule

// ===== hdl/hpc_pkg.sv
// Purpose: Constants and types for the host port command, boot and transfer block.
// Assumes: A byte-wide host bus on one side, and a DSP core on Avalon-MM on the other.
// Notes: Host byte addresses are the pin addresses; DSP-side offsets are byte addresses.
package hpc_pkg;
    // Exception vector addresses.
    localparam logic [15:0] HPC_VEC_RECEIVE = 16'h0020;
    localparam logic [15:0] HPC_VEC_TRANSMIT = 16'h0022;
    localparam int HPC_VEC_SHIFT = 1;
    // Host byte addresses.
    localparam logic [2:0] HPC_HA_CONTROL = 3'h0;
    localparam logic [2:0] HPC_HA_VECTOR = 3'h1;
    localparam logic [2:0] HPC_HA_STATUS = 3'h2;
    localparam logic [2:0] HPC_HA_UNUSED = 3'h4;
    localparam logic [2:0] HPC_HA_HIGH = 3'h5;
    localparam logic [2:0] HPC_HA_MID = 3'h6;
    localparam logic [2:0] HPC_HA_LOW = 3'h7;
    // Host control field positions.
    localparam int HPC_HC_RX_REQ = 0;
    localparam int HPC_HC_TX_REQ = 1;
    localparam int HPC_HC_FLAG0 = 3;
    localparam int HPC_HC_MODE_LO = 5;
    localparam int HPC_HC_MODE_HI = 6;
    localparam int HPC_HC_INIT = 7;
    // Command vector register fields and reset vector.
    localparam int HPC_CV_REQ = 7;
    localparam logic [5:0] HPC_CV_RESET = 6'h12;
    // Host status field positions.
    localparam int HPC_HS_RX_FULL = 0;
    localparam int HPC_HS_TX_EMPTY = 1;
    // DSP-side Avalon byte offsets.
    localparam logic [3:0] HPC_OFS_CONTROL = 4'h0;
    localparam logic [3:0] HPC_OFS_STATUS = 4'h4;
    localparam logic [3:0] HPC_OFS_TRANSMIT = 4'h8;
    localparam logic [3:0] HPC_OFS_RECEIVE = 4'hc;
    // DSP-side control and status field positions.
    localparam int HPC_DC_RX_IE = 0;
    localparam int HPC_DC_TX_IE = 1;
    localparam int HPC_DC_CMD_IE = 2;
    localparam int HPC_DS_RX_FULL = 0;
    localparam int HPC_DS_TX_EMPTY = 1;
    localparam int HPC_DS_CMD_PEND = 2;
    localparam int HPC_DS_FLAG0 = 3;
    // Boot mode code and word limit.
    localparam logic [2:0] HPC_BOOT_HOST = 3'b101;
    localparam int HPC_BOOT_WORDS = 512;
    // Host bus request carried as one unit.
    typedef struct packed {
        logic read;
        logic write;
        logic [2:0] addr;
        logic [7:0] wdata;
    } hpc_host_req_type;
endpackage

// ===== test/hpc_host_port_properties.sv
// Purpose: Port-level checks on the host port block.
// Assumes: One clock domain.
// Notes: Command vectors run from 16'h0000 to 16'h007e; only those above the transmit vector count as commands here.
`timescale 1ns/1ps
module hpc_host_port_properties #(
    parameter int WORD_W = 24,
    parameter int BOOT_WORDS = 512
) (
    // Clock and reset.
    input wire logic mclk_in,
    input wire logic rst_in,
    // Host byte bus.
    input wire hpc_pkg::hpc_host_req_type host_req_in,
    input wire logic [7:0] host_rdata_out,
    input wire logic host_request_pin_out,
    // Core Avalon-MM slave.
    input wire logic [3:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [31:0] avs_writedata_in,
    input wire logic [31:0] avs_readdata_out,
    input wire logic avs_waitrequest_out,
    // Core exception handshake.
    input wire logic core_irq_enable_in,
    input wire logic exc_ack_in,
    input wire logic exc_req_out,
    input wire logic [15:0] exc_vector_out,
    // Boot pins and status.
    input wire logic boot_mode_pin_a_in,
    input wire logic boot_mode_pin_b_in,
    input wire logic boot_mode_pin_c_in,
    input wire logic boot_load_out,
    input wire logic boot_done_out
);
    import hpc_pkg::*;
    logic ctl_rx_reg; // Host rx request enable.
    logic ctl_tx_reg; // Host tx request enable.
    logic [5:0] vec_reg; // Host vector number.
    logic [1:0] cnt_reg; // Edges since reset, up to three.
    logic [2:0] mode; // Boot pins as c, b, a.
    logic is_cmd; // A command exception is on show.
    assign mode = {boot_mode_pin_c_in, boot_mode_pin_b_in, boot_mode_pin_a_in};
    assign is_cmd = exc_req_out && (exc_vector_out > HPC_VEC_TRANSMIT);
    // Mirrors host control and vector writes.
    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            ctl_rx_reg <= 1'b0;
            ctl_tx_reg <= 1'b0;
            vec_reg <= HPC_CV_RESET;
            cnt_reg <= 2'h0;
        end else begin
            cnt_reg <= (cnt_reg == 2'h3) ? cnt_reg : cnt_reg + 2'h1;
            if (host_req_in.write && host_req_in.addr == HPC_HA_CONTROL) begin
                ctl_rx_reg <= host_req_in.wdata[HPC_HC_RX_REQ];
                ctl_tx_reg <= host_req_in.wdata[HPC_HC_TX_REQ];
            end
            if (host_req_in.write && host_req_in.addr == HPC_HA_VECTOR) begin
                vec_reg <= host_req_in.wdata[5:0];
            end
        end
    end
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (rst_in);
    AST_AV_ONE_WAIT: assert property ($rose(avs_read_in || avs_write_in) |-> avs_waitrequest_out ##1 !avs_waitrequest_out)
        else $error("wait not one cycle");
    AST_UNUSED_ZERO: assert property (host_req_in.read && host_req_in.addr == HPC_HA_UNUSED |=> host_rdata_out == 8'h00)
        else $error("unused byte not zero");
    AST_VEC_RANGE: assert property (exc_req_out |-> !exc_vector_out[0] && exc_vector_out <= 16'h007e)
        else $error("bad vector");
    AST_IRQ_GATED: assert property (!core_irq_enable_in |=> !exc_req_out)
        else $error("exception while masked");
    AST_CMD_VECTOR: assert property (is_cmd |-> exc_vector_out == {9'h000, vec_reg, 1'b0})
        else $error("command vector not doubled");
    AST_ACK_CLEARS: assert property (exc_ack_in && is_cmd |-> ##2 !is_cmd)
        else $error("command after ack");
    AST_CANCEL: assert property (host_req_in.write && host_req_in.addr == HPC_HA_VECTOR
        && !host_req_in.wdata[HPC_CV_REQ] |-> ##2 !is_cmd)
        else $error("cancelled command still taken");
    AST_PIN_QUIET: assert property ((!ctl_rx_reg && !ctl_tx_reg) [*2] |-> !host_request_pin_out)
        else $error("pin high while disabled");
    AST_BOOT_SELECT: assert property (cnt_reg == 2'h1 |=> boot_load_out == ($past(mode, 2) == HPC_BOOT_HOST))
        else $error("boot load wrong");
    AST_DONE_STICKY: assert property (boot_done_out |=> boot_done_out)
        else $error("boot done fell");
    COV_TX_EXC: cover property (exc_req_out && exc_vector_out == HPC_VEC_TRANSMIT);
    COV_CMD_ACK: cover property (exc_ack_in && is_cmd);
    COV_PIN: cover property (host_request_pin_out);
endmodule
bind hpc_host_port hpc_host_port_properties #(.WORD_W(WORD_W), .BOOT_WORDS(BOOT_WORDS)) u_props (
    .mclk_in(mclk_in), .rst_in(rst_in), .host_req_in(host_req_in), .host_rdata_out(host_rdata_out),
    .host_request_pin_out(host_request_pin_out), .avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
    .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in), .avs_readdata_out(avs_readdata_out),
    .avs_waitrequest_out(avs_waitrequest_out), .core_irq_enable_in(core_irq_enable_in), .exc_ack_in(exc_ack_in),
    .exc_req_out(exc_req_out), .exc_vector_out(exc_vector_out), .boot_mode_pin_a_in(boot_mode_pin_a_in),
    .boot_mode_pin_b_in(boot_mode_pin_b_in), .boot_mode_pin_c_in(boot_mode_pin_c_in),
    .boot_load_out(boot_load_out), .boot_done_out(boot_done_out));

// ===== test/hpc_host_model.sv
// Purpose: Behavioural host processor on the byte-wide port.
// Assumes: One-cycle accesses; read data taken a cycle later.
// Notes: Idle write data shows the inverse of the last byte after a write; each read inverts it again.
`timescale 1ns/1ps
module hpc_host_model (
    // Clock.
    input wire logic mclk_in,
    // Byte bus.
    input wire logic [7:0] host_rdata_in,
    output hpc_pkg::hpc_host_req_type host_req_out
);
    import hpc_pkg::*;
    // Bus idles at time zero.
    initial begin
        host_req_out = '0;
    end
    // One write cycle; then data inverts.
    task automatic wr(input logic [2:0] a, input logic [7:0] v);
        @(posedge mclk_in);
        host_req_out <= '{read: 1'b0, write: 1'b1, addr: a, wdata: v};
        @(posedge mclk_in);
        host_req_out <= '{read: 1'b0, write: 1'b0, addr: a, wdata: ~v};
    endtask
    // One read cycle; byte taken an edge later.
    task automatic rd(input logic [2:0] a, output logic [7:0] v);
        @(posedge mclk_in);
        host_req_out <= '{read: 1'b1, write: 1'b0, addr: a, wdata: ~host_req_out.wdata};
        @(posedge mclk_in);
        host_req_out.read <= 1'b0;
        @(posedge mclk_in);
        v = host_rdata_in;
    endtask
    // Four bytes a word, dummy first, low last.
    task automatic send_word(input logic [23:0] w);
        wr(HPC_HA_UNUSED, 8'h00);
        wr(HPC_HA_HIGH, w[23:16]);
        wr(HPC_HA_MID, w[15:8]);
        wr(HPC_HA_LOW, w[7:0]);
    endtask
endmodule

// ===== test/hpc_host_port_tb.sv
// Purpose: Self-checking bench for the host port block.
// Assumes: The model drives the host bus; the bench is the core.
// Notes: Boot limit is four words.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin failures++; $display("wrong value %s expected %h seen %h", nm, e, g); end end
module hpc_host_port_tb;
    import hpc_pkg::*;
    int failures = 0; // Mismatches seen.
    int n_checks = 0; // Comparisons made.
    logic mclk_in = 1'b0;
    logic rst_in = 1'b1;
    hpc_host_req_type host_req;
    logic [7:0] host_rdata;
    logic pin;
    logic [3:0] avs_address_in = 4'h0;
    logic avs_read_in = 1'b0;
    logic avs_write_in = 1'b0;
    logic [31:0] avs_writedata_in = 32'h0;
    logic [31:0] avs_readdata_out;
    logic avs_waitrequest_out;
    logic core_irq_enable_in = 1'b0;
    logic exc_ack_in = 1'b0;
    logic exc_req_out;
    logic [15:0] exc_vector_out;
    logic boot_load_out;
    logic boot_done_out;
    logic [31:0] d;
    logic [7:0] b;
    int i;
    hpc_host_port #(.BOOT_WORDS(4)) u_hpc_host_port (.mclk_in(mclk_in), .rst_in(rst_in), .host_req_in(host_req),
        .host_rdata_out(host_rdata), .host_request_pin_out(pin), .avs_address_in(avs_address_in),
        .avs_read_in(avs_read_in), .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
        .avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out),
        .core_irq_enable_in(core_irq_enable_in), .exc_ack_in(exc_ack_in), .exc_req_out(exc_req_out),
        .exc_vector_out(exc_vector_out), .boot_mode_pin_a_in(1'b1), .boot_mode_pin_b_in(1'b0),
        .boot_mode_pin_c_in(1'b1), .boot_load_out(boot_load_out), .boot_done_out(boot_done_out));
    hpc_host_model host_bus (.mclk_in(mclk_in), .host_rdata_in(host_rdata), .host_req_out(host_req));
    // Prints counts and verdict, then ends.
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // Write held until waitrequest is low.
    task automatic av_wr(input logic [3:0] a, input logic [31:0] v);
        @(posedge mclk_in);
        avs_address_in <= a;
        avs_writedata_in <= v;
        avs_write_in <= 1'b1;
        do @(posedge mclk_in); while (avs_waitrequest_out !== 1'b0);
        avs_write_in <= 1'b0;
    endtask
    // Read; data taken at the accepting edge.
    task automatic av_rd(input logic [3:0] a, output logic [31:0] v);
        @(posedge mclk_in);
        avs_address_in <= a;
        avs_read_in <= 1'b1;
        do @(posedge mclk_in); while (avs_waitrequest_out !== 1'b0);
        v = avs_readdata_out;
        avs_read_in <= 1'b0;
    endtask
    // Waits for an exception and checks its vector.
    task automatic wait_exc(input logic [15:0] v);
        for (int k = 0; k < 20 && exc_req_out !== 1'b1; k++) @(posedge mclk_in);
        #1 `CHK("exception", {1'b1, v}, {exc_req_out, exc_vector_out})
    endtask
    // Host reads the three receive bytes.
    task automatic rx_word(input logic [23:0] w);
        logic [7:0] r;
        for (int k = 0; k < 3; k++) begin
            host_bus.rd(3'(HPC_HA_HIGH + k), r);
            `CHK("host byte", w[23 - 8 * k -: 8], r)
        end
    endtask
    // Free-running clock.
    initial begin
        forever #2 mclk_in = ~mclk_in;
    end
    // Cuts a hang short.
    initial begin
        #40000;
        failures++;
        tally_and_finish();
    end
    // Main sequence.
    initial begin
        repeat (3) @(posedge mclk_in);
        rst_in <= 1'b0;
        core_irq_enable_in <= 1'b1;
        repeat (3) @(posedge mclk_in);
        #1 `CHK("boot load", 1'b1, boot_load_out)
        for (i = 0; i < 4; i++) begin
            host_bus.send_word({8'h5a, 8'h00, 8'(i)});
            av_rd(HPC_OFS_RECEIVE, d);
            `CHK("boot word", {16'h005a, 8'h00, 8'(i)}, d)
            repeat (2) @(posedge mclk_in);
            #1 `CHK("boot done", i == 3, boot_done_out)
        end
        host_bus.rd(HPC_HA_UNUSED, b);
        `CHK("unused byte", 8'h00, b)
        av_rd(4'h2, d);
        `CHK("unmapped read", 32'h0, d)
        // Core to host; second word waits.
        av_wr(HPC_OFS_TRANSMIT, 32'h00abcdef);
        host_bus.wr(HPC_HA_CONTROL, 8'h01);
        host_bus.rd(HPC_HA_STATUS, b);
        #1 `CHK("host rx full", 2'b11, {b[0], pin})
        av_rd(HPC_OFS_STATUS, d);
        `CHK("core tx empty", 1'b1, d[HPC_DS_TX_EMPTY])
        av_wr(HPC_OFS_TRANSMIT, 32'h00123abc);
        av_rd(HPC_OFS_STATUS, d);
        `CHK("core tx busy", 1'b0, d[HPC_DS_TX_EMPTY])
        av_wr(HPC_OFS_CONTROL, 32'h2);
        rx_word(24'habcdef);
        wait_exc(HPC_VEC_TRANSMIT);
        rx_word(24'h123abc);
        host_bus.rd(HPC_HA_STATUS, b);
        repeat (2) @(posedge mclk_in);
        #1 `CHK("rx full and pin", 2'b00, {b[0], pin})
        // Host to core with the receive exception.
        av_wr(HPC_OFS_CONTROL, 32'h1);
        host_bus.send_word(24'h13579b);
        wait_exc(HPC_VEC_RECEIVE);
        av_rd(HPC_OFS_RECEIVE, d);
        `CHK("core receive", 32'h0013579b, d)
        // Command held off in DMA mode, then taken.
        av_wr(HPC_OFS_CONTROL, 32'h4);
        host_bus.wr(HPC_HA_CONTROL, 8'h60);
        host_bus.wr(HPC_HA_VECTOR, 8'h95);
        av_rd(HPC_OFS_STATUS, d);
        #1 `CHK("pending in dma", 2'b10, {d[HPC_DS_CMD_PEND], exc_req_out})
        host_bus.wr(HPC_HA_CONTROL, 8'h00);
        wait_exc(16'h002a);
        host_bus.rd(HPC_HA_VECTOR, b);
        `CHK("request shown", 8'h95, b)
        @(posedge mclk_in);
        exc_ack_in <= 1'b1;
        @(posedge mclk_in);
        exc_ack_in <= 1'b0;
        host_bus.rd(HPC_HA_VECTOR, b);
        av_rd(HPC_OFS_STATUS, d);
        `CHK("request cleared", 9'h015, {d[HPC_DS_CMD_PEND], b})
        // Command cancelled before the core may take it.
        av_wr(HPC_OFS_CONTROL, 32'h0);
        host_bus.wr(HPC_HA_VECTOR, 8'h95);
        host_bus.wr(HPC_HA_VECTOR, 8'h15);
        av_wr(HPC_OFS_CONTROL, 32'h4);
        av_rd(HPC_OFS_STATUS, d);
        #1 `CHK("cancelled", 2'b00, {d[HPC_DS_CMD_PEND], exc_req_out})
        av_wr(HPC_OFS_CONTROL, 32'h0);
        // Initialise bit self-clears, empties transmit.
        host_bus.wr(HPC_HA_CONTROL, 8'h80);
        host_bus.rd(HPC_HA_CONTROL, b);
        `CHK("init bit", 1'b0, b[HPC_HC_INIT])
        host_bus.rd(HPC_HA_STATUS, b);
        `CHK("host tx empty", 2'b10, b[1:0])
        tally_and_finish();
    end
endmodule
